// File: shared/tuner_pwr_pkg.sv
package tuner_pwr_pkg;

   // -----------------------------------------------------------------
   // power modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_HW_OFF,
      MODE_DEEP_SLEEP,
      MODE_OSC_KEEP
   } power_mode_t;

   // -----------------------------------------------------------------
   // field widths, codes and reset values
   // -----------------------------------------------------------------
   localparam int DIAG_W   = 3;
   localparam int BBL_W    = 2;
   localparam int DIV_W    = 5;

   localparam logic [DIAG_W-1:0] DIAG_LO_ROUTE   = 3'h7;
   localparam logic [DIAG_W-1:0] DIAG_PDET_VOLT  = 3'h4;
   localparam logic [BBL_W-1:0]  BBL_LOWER       = 2'h0;
   localparam logic [BBL_W-1:0]  BBL_NOMINAL     = 2'h1;
   localparam logic [BBL_W-1:0]  BBL_HIGH        = 2'h3;
   localparam logic [DIV_W-1:0]  DIV_OFF         = 5'h00;

   // defaults taken only at power application
   localparam logic              RST_DEEP_SLEEP  = 1'b0;
   localparam logic              RST_OSC_KEEP    = 1'b0;
   localparam logic              RST_PDET_EN     = 1'b0;
   localparam logic              RST_QUAD_PATH_OFF        = 1'b0;
   localparam logic [BBL_W-1:0]  RST_BBL         = 2'h1;
   localparam logic              RST_GAIN_STEP   = 1'b0;
   localparam logic              RST_PREBIAS     = 1'b1;
   localparam logic [DIV_W-1:0]  RST_DIV         = 5'h01;
   localparam logic [DIAG_W-1:0] RST_DIAG        = 3'h0;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic              deep_sleep_bit;
      logic              osc_keepalive_bit;
      logic              power_detector_enable;
      logic              quad_path_off;
      logic [BBL_W-1:0]  baseband_linearity;
      logic              qpsk_gain_step;
      logic              pump_prebias_enable;
      logic [DIV_W-1:0]  ref_out_divide;
      logic [DIAG_W-1:0] diag_select;
   } ctrl_bits_t;

   localparam ctrl_bits_t CTRL_RESET = '{
      deep_sleep_bit:        RST_DEEP_SLEEP,
      osc_keepalive_bit:     RST_OSC_KEEP,
      power_detector_enable: RST_PDET_EN,
      quad_path_off:         RST_QUAD_PATH_OFF,
      baseband_linearity:    RST_BBL,
      qpsk_gain_step:        RST_GAIN_STEP,
      pump_prebias_enable:   RST_PREBIAS,
      ref_out_divide:        RST_DIV,
      diag_select:           RST_DIAG
   };

   typedef struct packed {
      logic signal_path_on;
      logic i_path_on;
      logic q_path_on;
      logic serial_if_on;
      logic osc_on;
      logic ref_buf_on;
      logic ref_div_on;
      logic pdet_on;
      logic pdet_voltage_mode;
      logic lo_to_diag;
      logic gain_step_on;
      logic prebias_on;
      logic bbl_lower;
      logic bbl_nominal;
      logic bbl_high;
   } enables_t;

endpackage

// File: design/ctrl_hold.sv
`timescale 1ns/1ps
module ctrl_hold
   import tuner_pwr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire ctrl_bits_t wr_data,
   output      ctrl_bits_t rd_data
);
   // -----------------------------------------------------------------
   // control storage: defaults only on power-up reset
   // -----------------------------------------------------------------
   ctrl_bits_t bits_d;
   ctrl_bits_t bits_q;

   always_comb begin
      bits_d = bits_q;
      if (wr_en) begin
         bits_d = wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bits_q <= CTRL_RESET;
      end else begin
         bits_q <= bits_d;
      end
   end

   assign rd_data = bits_q;
endmodule

// File: design/tuner_power_mode_control.sv
`timescale 1ns/1ps
// How it works
// R01: pin low with power detector enable 0 gives hardware shutdown, all off.
// R02: a shutdown request from the pin overrides the deep-sleep and keepalive.
// R03: deep-sleep turns off all but the serial interface, which still writes.
// R04: keepalive leaves serial, oscillator, ref buffer and divider; path off.
// R05: control bits survive every low-power mode unchanged.
// R06: defaults load only at power-up reset, never on leaving a low mode.
// R07: diagnostic select all ones routes the LO to the diagnostic pin.
// R08: quadrature-path-off set turns the Q path off, leaving I.
// R09: linearity codes 00, 01, 11 give lower, nominal and high linearity.
// R10: gain-step bit 1 enables the baseband gain step, 0 bypasses it.
// R11: power detector enable 1 turns on the IF power detector.
// R12: pump-prebias enable 0 disables prebias, 1 enables it.
// R13: reference divide field all zeros disables the reference buffer.
// R14: diagnostic select 100 puts the power detector into voltage mode.
// R15: deep-sleep and keepalive both set gives deep-sleep, oscillator off.
module tuner_power_mode_control
   import tuner_pwr_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   input  wire logic        HW_POWER_OFF_N,
   input  wire logic        CTRL_WR,
   input  wire ctrl_bits_t  CTRL_WDATA,
   output      ctrl_bits_t  CTRL_RDATA,
   output      logic        CTRL_WR_ACCEPT,
   output      power_mode_t POWER_MODE,
   output      enables_t    ENABLES
);
   // -----------------------------------------------------------------
   // held control bits
   // -----------------------------------------------------------------
   ctrl_bits_t  bits;
   logic        serial_on;

   // writes land only while the serial interface is powered
   assign CTRL_WR_ACCEPT = serial_on;

   ctrl_hold u_hold (
      .clk     (REF_CLK),
      .rst     (RESET),                                      // R06
      .wr_en   (CTRL_WR & serial_on),                        // R03 R05
      .wr_data (CTRL_WDATA),
      .rd_data (bits)
   );

   assign CTRL_RDATA = bits;

   // -----------------------------------------------------------------
   // mode decode
   // -----------------------------------------------------------------
   power_mode_t mode_d;
   power_mode_t mode_q;

   always_comb begin
      if (!HW_POWER_OFF_N && !bits.power_detector_enable) begin
         mode_d = MODE_HW_OFF;                               // R01 R02
      end else if (bits.deep_sleep_bit) begin
         mode_d = MODE_DEEP_SLEEP;                           // R03 R15
      end else if (bits.osc_keepalive_bit) begin
         mode_d = MODE_OSC_KEEP;                             // R04
      end else begin
         mode_d = MODE_NORMAL;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         mode_q <= MODE_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign POWER_MODE = mode_q;
   assign serial_on  = (mode_q != MODE_HW_OFF);              // R01

   // -----------------------------------------------------------------
   // circuit enables
   // -----------------------------------------------------------------
   enables_t en_d;
   enables_t en_q;
   logic     active;
   logic     osc_run;

   always_comb begin
      active  = 1'b0;
      osc_run = 1'b0;
      unique case (mode_d)
         MODE_NORMAL: begin
            active  = 1'b1;
            osc_run = 1'b1;
         end
         MODE_HW_OFF: begin
            active  = 1'b0;
            osc_run = 1'b0;
         end
         MODE_DEEP_SLEEP: begin
            active  = 1'b0;
            osc_run = 1'b0;                                  // R15
         end
         MODE_OSC_KEEP: begin
            active  = 1'b0;
            osc_run = 1'b1;                                  // R04
         end
      endcase
      en_d = '0;
      en_d.signal_path_on = active;
      en_d.i_path_on      = active;
      en_d.q_path_on      = active & ~bits.quad_path_off;    // R08
      en_d.serial_if_on   = (mode_d != MODE_HW_OFF);         // R01 R03
      en_d.osc_on         = osc_run;
      en_d.ref_buf_on     = osc_run &
                            (bits.ref_out_divide != DIV_OFF); // R13
      en_d.ref_div_on     = en_d.ref_buf_on;                  // R04
      en_d.pdet_on        = active & bits.power_detector_enable; // R11
      en_d.pdet_voltage_mode = active &
                            (bits.diag_select == DIAG_PDET_VOLT); // R14
      en_d.lo_to_diag     = active &
                            (bits.diag_select == DIAG_LO_ROUTE);  // R07
      en_d.gain_step_on   = active & bits.qpsk_gain_step;    // R10
      en_d.prebias_on     = active & bits.pump_prebias_enable; // R12
      en_d.bbl_lower      = active &
                            (bits.baseband_linearity == BBL_LOWER);   // R09
      en_d.bbl_nominal    = active &
                            (bits.baseband_linearity == BBL_NOMINAL); // R09
      en_d.bbl_high       = active &
                            (bits.baseband_linearity == BBL_HIGH);    // R09
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         en_q <= '0;
      end else begin
         en_q <= en_d;
      end
   end

   assign ENABLES = en_q;
endmodule

// File: test/host_model.sv
`timescale 1ns/1ps
module host_model
   import tuner_pwr_pkg::*;
(
   input  wire logic       clk,
   output      logic       pin_n,
   output      logic       wr,
   output      ctrl_bits_t wdata
);
   initial begin
      pin_n = 1'b1;
      wr    = 1'b0;
      wdata = CTRL_RESET;
   end
   // one-cycle strobe; data turns over once released
   task automatic write(input ctrl_bits_t w);
      @(posedge clk);
      #1;
      wr    = 1'b1;
      wdata = w;
      @(posedge clk);
      #1;
      wr    = 1'b0;
      wdata = ~w;
   endtask
   task automatic pin(input logic v);
      @(posedge clk);
      #1;
      pin_n = v;
   endtask
endmodule

// File: test/tuner_pwr_assertions.sv
`timescale 1ns/1ps
module tuner_pwr_checker
   import tuner_pwr_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RESET,
   input wire logic        HW_POWER_OFF_N,
   input wire logic        CTRL_WR,
   input wire ctrl_bits_t  CTRL_WDATA,
   input wire ctrl_bits_t  CTRL_RDATA,
   input wire logic        CTRL_WR_ACCEPT,
   input wire power_mode_t POWER_MODE,
   input wire enables_t    ENABLES
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   ctrl_bits_t c_q;
   logic       pin_ok;
   logic       run;
   logic       wr_ok;
   assign pin_ok = HW_POWER_OFF_N | CTRL_RDATA.power_detector_enable;
   assign run    = pin_ok & !CTRL_RDATA.deep_sleep_bit
                   & !CTRL_RDATA.osc_keepalive_bit;
   assign wr_ok  = CTRL_WR & CTRL_WR_ACCEPT;
   always_ff @(posedge REF_CLK) begin
      c_q <= CTRL_RDATA;
   end
   property p_off;
      !pin_ok |=> POWER_MODE == MODE_HW_OFF && ENABLES == 15'h0000;
   endproperty
   a_off: assert property (p_off) else $error("no shutdown");
   property p_acc;
      CTRL_WR_ACCEPT == (POWER_MODE != MODE_HW_OFF)
      && (CTRL_WR_ACCEPT || ENABLES == 15'h0000);
   endproperty
   a_acc: assert property (p_acc) else $error("accept wrong");
   property p_deep;
      pin_ok && CTRL_RDATA.deep_sleep_bit |=>
         POWER_MODE == MODE_DEEP_SLEEP && ENABLES == 15'h0800;
   endproperty
   a_deep: assert property (p_deep) else $error("deep");
   property p_keep;
      pin_ok && !CTRL_RDATA.deep_sleep_bit && CTRL_RDATA.osc_keepalive_bit
      |=> POWER_MODE == MODE_OSC_KEEP && ENABLES[14:10] == 5'h03
          && ENABLES[7:0] == 8'h00
          && ENABLES.ref_buf_on == (c_q.ref_out_divide != DIV_OFF);
   endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_run;
      run |=> POWER_MODE == MODE_NORMAL
         && ENABLES[14:10] == {2'h3, !c_q.quad_path_off, 2'h3}
         && ENABLES.pdet_on == c_q.power_detector_enable
         && ENABLES.gain_step_on == c_q.qpsk_gain_step
         && ENABLES.prebias_on == c_q.pump_prebias_enable;
   endproperty
   a_run: assert property (p_run) else $error("run");
   property p_diag;
      run |=> ENABLES.lo_to_diag == (c_q.diag_select == DIAG_LO_ROUTE)
         && ENABLES.pdet_voltage_mode == (c_q.diag_select == DIAG_PDET_VOLT)
         && ENABLES[2:0] == {c_q.baseband_linearity == BBL_LOWER,
            c_q.baseband_linearity == BBL_NOMINAL,
            c_q.baseband_linearity == BBL_HIGH};
   endproperty
   a_diag: assert property (p_diag) else $error("diag");
   property p_wr;
      wr_ok |=> CTRL_RDATA == $past(CTRL_WDATA);
   endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_hold;
      !wr_ok |=> $stable(CTRL_RDATA);
   endproperty
   a_hold: assert property (p_hold) else $error("bits moved");
endmodule
bind tuner_power_mode_control tuner_pwr_checker chk (.REF_CLK, .RESET,
   .HW_POWER_OFF_N, .CTRL_WR, .CTRL_WDATA, .CTRL_RDATA, .CTRL_WR_ACCEPT,
   .POWER_MODE, .ENABLES);

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   error_cnt++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench
   import tuner_pwr_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        pin_n, wr, acc;
   ctrl_bits_t  wdata, rdata, w, v;
   power_mode_t mode;
   enables_t    en;
   int          error_cnt = 0;
   int          samples_checked = 0;
   initial begin
      forever #50 clk = ~clk;
   end
   host_model host (.clk(clk), .pin_n(pin_n), .wr(wr), .wdata(wdata));
   tuner_power_mode_control uut (.REF_CLK(clk), .RESET(rst),
      .HW_POWER_OFF_N(pin_n), .CTRL_WR(wr), .CTRL_WDATA(wdata),
      .CTRL_RDATA(rdata), .CTRL_WR_ACCEPT(acc), .POWER_MODE(mode),
      .ENABLES(en));
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task t_reset;
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      settle;
      `CHK(rdata, CTRL_RESET);
      `CHK(mode, MODE_NORMAL);
   endtask
   task t_fields;
      logic [1:0] code [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      logic [2:0] flag [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
      logic [2:0] diag [4] = '{3'h7, 3'h4, 3'h0, 3'h3};
      for (int i = 0; i < 4; i++) begin
         w = CTRL_RESET;
         w.quad_path_off = i[0];
         w.qpsk_gain_step = i[0];
         w.pump_prebias_enable = !i[0];
         w.power_detector_enable = i[1];
         w.baseband_linearity = code[i];
         w.ref_out_divide = i[0] ? DIV_OFF : 5'h1f;
         w.diag_select = diag[i];
         host.write(w);
         settle;
         `CHK(en.q_path_on, !w.quad_path_off);
         `CHK(en.gain_step_on, w.qpsk_gain_step);
         `CHK(en.pdet_on, w.power_detector_enable);
         `CHK(en.prebias_on, w.pump_prebias_enable);
         `CHK(en.ref_buf_on, w.ref_out_divide != 5'h00);
         `CHK(en.lo_to_diag, diag[i] == 3'h7);
         `CHK(en.pdet_voltage_mode, diag[i] == 3'h4);
         `CHK(en[2:0], flag[i]);
      end
   endtask
   task t_low;
      w = CTRL_RESET;
      w.deep_sleep_bit = 1'b1;
      w.osc_keepalive_bit = 1'b1;
      host.write(w);
      settle;
      `CHK(mode, MODE_DEEP_SLEEP);
      `CHK(en, 15'h0800);
      w.deep_sleep_bit = 1'b0;
      host.write(w);
      settle;
      `CHK(rdata, w);
      `CHK(mode, MODE_OSC_KEEP);
      `CHK(en, 15'h0f00);
   endtask
   task t_hw_power_off_n;
      v = w;
      host.pin(1'b0);
      settle;
      `CHK(mode, MODE_HW_OFF);
      `CHK(en, 15'h0000);
      `CHK(acc, 1'b0);
      host.write(CTRL_RESET);
      host.pin(1'b1);
      settle;
      `CHK(rdata, v);
      `CHK(mode, MODE_OSC_KEEP);
      w = CTRL_RESET;
      w.power_detector_enable = 1'b1;
      host.write(w);
      host.pin(1'b0);
      settle;
      `CHK(mode, MODE_NORMAL);
      host.pin(1'b1);
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      t_reset;
      t_fields;
      t_low;
      t_hw_power_off_n;
      t_reset;
      report_and_stop;
   end
endmodule
